// ### verilog/pmc_defs.svh
// register offsets, field positions, reset values and timing counts of the power-mode controller
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// byte offsets on the register bus
`define PMC_OFS_POWER_CTL   4'h0
`define PMC_OFS_REF_CTL     4'h4
`define PMC_OFS_TIMER_CTL   4'h8
`define PMC_OFS_STATUS      4'hC

// power_control_reg fields
`define PMC_BIT_IDLE        0
`define PMC_BIT_STOP        1
`define PMC_BIT_SUSPEND     2

// reference_control_reg fields
`define PMC_BIT_TEMPCO      0

// timer control fields
`define PMC_BIT_WDT_EN      0
`define PMC_BIT_MCD_EN      1
`define PMC_BIT_WDT_KICK    2

// status fields
`define PMC_POS_MODE        0
`define PMC_POS_CAUSE       4

// reset values
`define PMC_RST_SEL         1'b0
`define PMC_RST_WDT_EN      1'b0
`define PMC_RST_MCD_EN      1'b0
`define PMC_RST_TEMPCO      1'b0

// timing
`define PMC_CLK_MHZ         250
`define PMC_MCD_TIMEOUT_US  100
`define PMC_MCD_CYCLES      (`PMC_MCD_TIMEOUT_US * `PMC_CLK_MHZ)
`define PMC_WDT_CYCLES      65536
`define PMC_RSTSEQ_CYCLES   4'hF

`endif

// ### verilog/pmc_pkg.sv
// types shared by the power-mode controller
package pmc_pkg;

    typedef enum logic [2:0] {
        PMC_RUN,
        PMC_IDLE,
        PMC_STOP,
        PMC_SUSPEND,
        PMC_RESET
    } pmc_mode_e;

    typedef enum logic [1:0] {
        PMC_CAUSE_POR,
        PMC_CAUSE_EXT,
        PMC_CAUSE_WDT,
        PMC_CAUSE_MCD
    } pmc_cause_e;

endpackage : pmc_pkg

// ### verilog/pmc_tmr_if.sv
// carrier between the controller and its two timeout counters
`timescale 1ns/1ps
interface pmc_tmr_if;
    logic run;
    logic clear;
    logic expired;

    modport ctl (output run, output clear, input expired);
    modport tmr (input run, input clear, output expired);
endinterface : pmc_tmr_if

// ### verilog/pmc_watchdog.sv
// watchdog counter: expires after CYCLES clocks of running without a restart
`timescale 1ns/1ps
`include "pmc_defs.svh"
module pmc_watchdog #(
    parameter int unsigned CYCLES = `PMC_WDT_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // control
    pmc_tmr_if.tmr   t
);
    import pmc_pkg::*;

    localparam int unsigned W = $clog2(CYCLES + 1);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         expired;
    } pmc_wdt_s;

    pmc_wdt_s st_r;
    pmc_wdt_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.expired = 1'b0;
        // stopped counter loses its count so a fresh run starts full length
        if (!t.run || t.clear) begin
            st_nxt.cnt = '0;
        end else if (st_r.cnt == W'(CYCLES - 1)) begin
            st_nxt.cnt = '0;
            st_nxt.expired = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign t.expired = st_r.expired;
endmodule : pmc_watchdog

// ### verilog/pmc_clock_monitor.sv
// missing-clock detector: flags when no oscillator tick arrives for CYCLES clocks
`timescale 1ns/1ps
`include "pmc_defs.svh"
module pmc_clock_monitor #(
    parameter int unsigned CYCLES = `PMC_MCD_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // control: run is the enable, clear is the oscillator tick
    pmc_tmr_if.tmr   t
);
    import pmc_pkg::*;

    localparam int unsigned W = $clog2(CYCLES + 1);

    typedef struct packed {
        logic [W-1:0] gap;
        logic         expired;
    } pmc_mcd_s;

    pmc_mcd_s st_r;
    pmc_mcd_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.expired = 1'b0;
        if (!t.run || t.clear) begin
            st_nxt.gap = '0;
        end else if (st_r.gap == W'(CYCLES - 1)) begin
            // one flag per silent window; the reset that follows disarms it
            st_nxt.gap = '0;
            st_nxt.expired = 1'b1;
        end else begin
            st_nxt.gap = st_r.gap + W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign t.expired = st_r.expired;
endmodule : pmc_clock_monitor

// ### verilog/pmc_power_ctrl.sv
// power-mode controller: run, idle, stop and suspend with bus registers
// Summary of operation
// RULE_01: idle bit halts core after instruction
// RULE_02: idle keeps state, clocks and peripherals live
// RULE_03: only enabled interrupt or reset leaves idle
// RULE_04: interrupt wake clears idle bit, resumes core
// RULE_05: resume continues after the setting instruction
// RULE_06: reset wake runs reset, fetches from zero
// RULE_07: watchdog runs in idle, timeout resets
// RULE_08: software disables watchdog for endless idle
// RULE_09: stop bit enters stop after instruction
// RULE_10: stop halts oscillator, core, digital peripherals
// RULE_11: stop silences interrupts and timers, except detector
// RULE_12: only reset leaves stop
// RULE_13: missing-clock detector reset ends stop
// RULE_14: software disables detector for long stops
// RULE_15: oscillator off needs reset to restart
// RULE_16: suspend stops oscillator until wake event
// RULE_17: firmware sets temperature-coefficient bit before suspend
// RULE_18: any reset clears idle and stop bits
//
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "pmc_defs.svh"
module pmc_power_ctrl #(
    parameter int unsigned WDT_CYCLES = `PMC_WDT_CYCLES,
    parameter int unsigned MCD_CYCLES = `PMC_MCD_CYCLES
) (
    // clock, reset, enable
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    // register bus
    input  wire logic [3:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    // core side
    input  wire logic              instrDone,
    input  wire logic              irqPending,
    input  wire logic              extRstReq,
    input  wire logic              wakeEvent,
    input  wire logic              oscTick,
    output logic                   cpuHalt,
    output logic                   coreRst,
    output logic                   pcLoadZero,
    // clock and peripheral gating
    output logic                   intOscEn,
    output logic                   periphClkEn,
    output logic                   irqEn,
    output logic                   tempCoeffEn,
    output pmc_pkg::pmc_mode_e     powerMode
);
    import pmc_pkg::*;

    typedef struct packed {
        pmc_mode_e   mode;
        pmc_cause_e  cause;
        logic        idleSel;
        logic        stopSel;
        logic        suspSel;
        logic        tempCo;
        logic        wdtEn;
        logic        mcdEn;
        logic        wdtKick;
        logic [3:0]  rstCnt;
        logic        waitReq;
        logic [31:0] rdData;
        logic        cpuHalt;
        logic        coreRst;
        logic        pcZero;
        logic        oscEn;
        logic        periphEn;
        logic        irqEn;
    } pmc_state_s;

    pmc_state_s st_r;
    pmc_state_s st_nxt;

    pmc_tmr_if wdtBus ();
    pmc_tmr_if mcdBus ();

    logic       rstEvent;
    pmc_cause_e rstCause;
    logic       busWrite;

    // timeout counters
    pmc_watchdog #(
        .CYCLES (WDT_CYCLES)
    ) u_watchdog (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .t     (wdtBus)
    );

    pmc_clock_monitor #(
        .CYCLES (MCD_CYCLES)
    ) u_clock_monitor (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .t     (mcdBus)
    );

    // RULE_07 watchdog live in idle
    // RULE_11 watchdog stopped and cleared in stop
    assign wdtBus.run   = st_r.wdtEn && (st_r.mode == PMC_RUN || st_r.mode == PMC_IDLE);
    assign wdtBus.clear = st_r.wdtKick;

    // RULE_11 detector stays armed
    assign mcdBus.run   = st_r.mcdEn;
    assign mcdBus.clear = oscTick;

    // internal and external reset sources, external wins the cause field
    always_comb begin
        rstEvent = 1'b0;
        rstCause = PMC_CAUSE_POR;
        // RULE_13 detector timeout resets
        if (mcdBus.expired) begin
            rstEvent = 1'b1;
            rstCause = PMC_CAUSE_MCD;
        end
        // RULE_07 watchdog timeout resets
        if (wdtBus.expired) begin
            rstEvent = 1'b1;
            rstCause = PMC_CAUSE_WDT;
        end
        if (extRstReq) begin
            rstEvent = 1'b1;
            rstCause = PMC_CAUSE_EXT;
        end
    end

    // write lands on the edge where the master sees waitrequest low
    assign busWrite = avs_write && !st_r.waitReq && avs_byteenable[0];

    always_comb begin
        st_nxt = st_r;
        st_nxt.wdtKick = 1'b0;
        st_nxt.pcZero  = 1'b0;
        st_nxt.waitReq = 1'b1;

        // bus: one wait cycle, then a single ready cycle
        if ((avs_read || avs_write) && st_r.waitReq) begin
            st_nxt.waitReq = 1'b0;
            st_nxt.rdData  = '0;
            if (avs_read) begin
                unique case (avs_address)
                    `PMC_OFS_POWER_CTL: begin
                        st_nxt.rdData[`PMC_BIT_IDLE]    = st_r.idleSel;
                        st_nxt.rdData[`PMC_BIT_STOP]    = st_r.stopSel;
                        st_nxt.rdData[`PMC_BIT_SUSPEND] = st_r.suspSel;
                    end
                    `PMC_OFS_REF_CTL: begin
                        st_nxt.rdData[`PMC_BIT_TEMPCO] = st_r.tempCo;
                    end
                    `PMC_OFS_TIMER_CTL: begin
                        st_nxt.rdData[`PMC_BIT_WDT_EN] = st_r.wdtEn;
                        st_nxt.rdData[`PMC_BIT_MCD_EN] = st_r.mcdEn;
                    end
                    `PMC_OFS_STATUS: begin
                        st_nxt.rdData[`PMC_POS_MODE +: 3]  = st_r.mode;
                        st_nxt.rdData[`PMC_POS_CAUSE +: 2] = st_r.cause;
                    end
                    default: begin
                        st_nxt.rdData = '0;
                    end
                endcase
            end
        end

        if (busWrite) begin
            unique case (avs_address)
                `PMC_OFS_POWER_CTL: begin
                    st_nxt.idleSel = avs_writedata[`PMC_BIT_IDLE];
                    st_nxt.stopSel = avs_writedata[`PMC_BIT_STOP];
                    st_nxt.suspSel = avs_writedata[`PMC_BIT_SUSPEND];
                end
                `PMC_OFS_REF_CTL: begin
                    st_nxt.tempCo = avs_writedata[`PMC_BIT_TEMPCO];
                end
                `PMC_OFS_TIMER_CTL: begin
                    st_nxt.wdtEn   = avs_writedata[`PMC_BIT_WDT_EN];
                    st_nxt.mcdEn   = avs_writedata[`PMC_BIT_MCD_EN];
                    st_nxt.wdtKick = avs_writedata[`PMC_BIT_WDT_KICK];
                end
                default: begin
                    st_nxt.wdtKick = 1'b0;
                end
            endcase
        end

        unique case (st_r.mode)
            PMC_RUN: begin
                if (instrDone) begin
                    // stop outranks idle when both bits are set
                    if (st_r.stopSel) begin
                        // RULE_09 stop after instruction
                        st_nxt.mode = PMC_STOP;
                    end else if (st_r.suspSel) begin
                        // RULE_16 oscillator parked
                        st_nxt.mode = PMC_SUSPEND;
                    end else if (st_r.idleSel) begin
                        // RULE_01 idle after instruction
                        st_nxt.mode = PMC_IDLE;
                    end
                end
            end
            PMC_IDLE: begin
                // RULE_03 interrupt leaves idle
                if (irqPending) begin
                    // RULE_04 clear bit, resume
                    st_nxt.idleSel = 1'b0;
                    // RULE_05 program counter untouched
                    st_nxt.mode = PMC_RUN;
                end
            end
            PMC_STOP: begin
                // RULE_12 interrupts ignored here
                // RULE_15 only reset restarts
                st_nxt.mode = PMC_STOP;
            end
            PMC_SUSPEND: begin
                // RULE_16 wake restarts oscillator
                if (wakeEvent) begin
                    st_nxt.suspSel = 1'b0;
                    st_nxt.mode    = PMC_RUN;
                end
            end
            PMC_RESET: begin
                if (st_r.rstCnt == `PMC_RSTSEQ_CYCLES) begin
                    // RULE_06 fetch from zero
                    st_nxt.pcZero = 1'b1;
                    st_nxt.mode   = PMC_RUN;
                end else begin
                    st_nxt.rstCnt = st_r.rstCnt + 4'h1;
                end
            end
        endcase

        // RULE_06 any reset restarts sequence
        if (rstEvent) begin
            st_nxt.mode   = PMC_RESET;
            st_nxt.cause  = rstCause;
            st_nxt.rstCnt = '0;
            st_nxt.pcZero = 1'b0;
            // RULE_18 selects cleared
            st_nxt.idleSel = `PMC_RST_SEL;
            st_nxt.stopSel = `PMC_RST_SEL;
            st_nxt.suspSel = `PMC_RST_SEL;
            st_nxt.tempCo  = `PMC_RST_TEMPCO;
            st_nxt.wdtEn   = `PMC_RST_WDT_EN;
            st_nxt.mcdEn   = `PMC_RST_MCD_EN;
            st_nxt.wdtKick = 1'b0;
        end

        // gating follows the next mode so outputs leave flops
        st_nxt.cpuHalt = (st_nxt.mode != PMC_RUN);
        st_nxt.coreRst = (st_nxt.mode == PMC_RESET);
        // RULE_02 idle keeps clocks live
        // RULE_10 stop gates oscillator and peripherals
        st_nxt.oscEn    = !(st_nxt.mode == PMC_STOP || st_nxt.mode == PMC_SUSPEND);
        st_nxt.periphEn = (st_nxt.mode != PMC_STOP) && (st_nxt.mode != PMC_SUSPEND);
        // RULE_11 interrupts off in stop
        st_nxt.irqEn = (st_nxt.mode == PMC_RUN || st_nxt.mode == PMC_IDLE);
    end

    // power-on state: held in reset sequence so the core starts at zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r          <= '0;
            st_r.mode     <= PMC_RESET;
            st_r.cause    <= PMC_CAUSE_POR;
            st_r.waitReq  <= 1'b1;
            st_r.cpuHalt  <= 1'b1;
            st_r.coreRst  <= 1'b1;
            st_r.oscEn    <= 1'b1;
            st_r.periphEn <= 1'b1;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign avs_readdata    = st_r.rdData;
    assign avs_waitrequest = st_r.waitReq;
    assign cpuHalt         = st_r.cpuHalt;
    assign coreRst         = st_r.coreRst;
    assign pcLoadZero      = st_r.pcZero;
    assign intOscEn        = st_r.oscEn;
    assign periphClkEn     = st_r.periphEn;
    assign irqEn           = st_r.irqEn;
    assign tempCoeffEn     = st_r.tempCo;
    assign powerMode       = st_r.mode;

endmodule : pmc_power_ctrl

// ### tb/pmc_power_ctrl_assertions.sv
// port-level checks of the power-mode controller
`timescale 1ns/1ps
module pmc_power_ctrl_assertions (
    // clock and reset
    input wire logic          clk,
    input wire logic          rst_n,
    input wire logic          ce,
    // core side
    input wire logic          instrDone,
    input wire logic          irqPending,
    input wire logic          extRstReq,
    input wire logic          cpuHalt,
    input wire logic          coreRst,
    input wire logic          pcLoadZero,
    // gating
    input wire logic          intOscEn,
    input wire logic          periphClkEn,
    input wire logic          irqEn,
    input pmc_pkg::pmc_mode_e powerMode
);
    import pmc_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    // frozen cycles prove nothing
    default disable iff (!rst_n || !ce);
    // a fresh reset event would restart the count
    sequence sQuiet;
        $rose(coreRst) ##0 !extRstReq [*8] ##1 !extRstReq [*8];
    endsequence
    sequence sRun;
        !coreRst && pcLoadZero && powerMode == PMC_RUN;
    endsequence
    AST_RST_SEQ: assert property (sQuiet |-> coreRst ##1 sRun)
        else $error("reset sequence length wrong");
    AST_PCZ_ONCE: assert property (pcLoadZero |=> !pcLoadZero)
        else $error("pc reload pulse too long");
    AST_EXT_RST: assert property (extRstReq |=> powerMode == PMC_RESET && coreRst)
        else $error("reset request ignored");
    AST_IDLE_IN: assert property (
        $changed(powerMode) && powerMode == PMC_IDLE |-> $past(instrDone) && $past(powerMode) == PMC_RUN)
        else $error("idle entered without retire");
    AST_IDLE_STAY: assert property (
        powerMode == PMC_IDLE && !irqPending && !extRstReq |=> powerMode inside {PMC_IDLE, PMC_RESET})
        else $error("idle left without cause");
    AST_IDLE_WAKE: assert property (
        powerMode == PMC_IDLE && irqPending && !extRstReq
        |=> !pcLoadZero && (powerMode == PMC_RUN && !cpuHalt || coreRst))
        else $error("interrupt did not resume core");
    AST_STOP_STAY: assert property (
        powerMode == PMC_STOP && !extRstReq |=> powerMode inside {PMC_STOP, PMC_RESET})
        else $error("stop left without reset");
    AST_IDLE_LIVE: assert property (
        powerMode == PMC_IDLE |-> intOscEn && periphClkEn && irqEn && cpuHalt)
        else $error("idle gating wrong");
    AST_STOP_GATE: assert property (
        powerMode == PMC_STOP |-> !intOscEn && !periphClkEn && !irqEn && cpuHalt)
        else $error("stop gating wrong");
endmodule : pmc_power_ctrl_assertions

bind pmc_power_ctrl pmc_power_ctrl_assertions chk_u (.clk, .rst_n, .ce, .instrDone, .irqPending,
    .extRstReq, .cpuHalt, .coreRst, .pcLoadZero, .intOscEn, .periphClkEn, .irqEn, .powerMode);

// ### tb/pmc_core_model.sv
// behavioural core: retires instructions and ticks the internal oscillator
`timescale 1ns/1ps
module pmc_core_model (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // controller outputs
    input wire logic       cpuHalt,
    input wire logic       coreRst,
    input wire logic       intOscEn,
    // pacing, cycles between retirements
    input wire logic [1:0] gap,
    // to the controller
    output logic           instrDone,
    output logic           oscTick
);
    logic [1:0] cnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 2'h0;
            instrDone <= 1'b0;
            oscTick <= 1'b0;
        end else begin
            // ticks stand still while the oscillator is off
            oscTick <= intOscEn & ~oscTick;
            instrDone <= !cpuHalt && !coreRst && cnt == gap;
            cnt <= (cnt == gap) ? 2'h0 : cnt + 2'h1;
        end
    end
endmodule : pmc_core_model

// ### tb/tb_cpu_power_mode_control.sv
// self-checking bench of the power-mode controller against a behavioural model
`timescale 1ns/1ps
module tb_cpu_power_mode_control;
    import pmc_pkg::*;
    localparam int WDT = 20;
    localparam int MISSING_CLOCK_DETECTOR = 20;
    logic        clk, rst_n, ce, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd, v;
    logic        instrDone, irqPending, extRstReq, wakeEvent, oscTick;
    logic        cpuHalt, coreRst, pcLoadZero, intOscEn, periphClkEn, irqEn, tempCoeffEn;
    logic [1:0]  gap;
    pmc_mode_e   powerMode, expMode;
    int          nMismatch, testsRun, cause;
    logic [31:0] mdl [3];

    pmc_power_ctrl #(.WDT_CYCLES(WDT), .MCD_CYCLES(MISSING_CLOCK_DETECTOR)) dut_u (.*);
    pmc_core_model core_u (.*);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic testDone;
        $display("checks %0d mismatches %0d", testsRun, nMismatch);
        if (nMismatch == 0 && testsRun > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : testDone

    task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            nMismatch++;
            $display("ERROR t=%0t value %h, expected %h", $time, got, exp);
        end
    endtask : chkVal

    // waits a bounded span, then compares the mode
    task automatic waitMode(input pmc_mode_e e, input int lim);
        int n;
        n = 0;
        while (powerMode !== e && n < lim) begin
            @(posedge clk);
            n++;
        end
        testsRun++;
        expMode = e;
        if (powerMode !== e) begin
            nMismatch++;
            $display("ERROR t=%0t mode %0d, expected %0d", $time, powerMode, e);
        end
    endtask : waitMode

    // request held until waitrequest is seen low; only the 4000-cycle run limit ends a stall
    task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask : xfer

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        if (avs_byteenable[0] && a == 4'h0) mdl[0] = d & 32'h7;
        if (avs_byteenable[0] && a == 4'h4) mdl[1] = d & 32'h1;
        // kick bit is write-only
        if (avs_byteenable[0] && a == 4'h8) mdl[2] = d & 32'h3;
    endtask : wr

    task automatic rdc(input logic [3:0] a);
        xfer(1'b0, a, 32'h0);
        case (a)
            4'h0, 4'h4, 4'h8: chkVal(rd, mdl[a[3:2]]);
            4'hC: chkVal(rd, {26'h0, cause[1:0], 1'b0, expMode});
            default: chkVal(rd, 32'h0);
        endcase
    endtask : rdc

    task automatic rstModel(input int c, input int lim);
        mdl = '{default: 32'h0};
        cause = c;
        waitMode(PMC_RESET, lim);
        waitMode(PMC_RUN, 20);
        for (int a = 0; a < 16; a += 4) rdc(4'(a));
    endtask : rstModel

    // stop beats suspend beats idle
    function automatic pmc_mode_e nextMode(input logic [31:0] p);
        if (p[1]) return PMC_STOP;
        if (p[2]) return PMC_SUSPEND;
        return p[0] ? PMC_IDLE : PMC_RUN;
    endfunction : nextMode

    // one-cycle strobe: 0 interrupt, 1 wake, 2 external reset
    task automatic pulse(input int k);
        if (k == 0) irqPending <= 1'b1;
        else if (k == 1) wakeEvent <= 1'b1;
        else extRstReq <= 1'b1;
        @(posedge clk);
        irqPending <= 1'b0;
        wakeEvent <= 1'b0;
        extRstReq <= 1'b0;
        @(posedge clk);
    endtask : pulse

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        irqPending = 1'b0;
        extRstReq = 1'b0;
        wakeEvent = 1'b0;
        gap = 2'h1;
        nMismatch = 0;
        testsRun = 0;
        cause = 0;
        mdl = '{default: 32'h0};
        v = $urandom(64);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        waitMode(PMC_RUN, 20);
        wr(4'h2, 32'hFF);
        for (int a = 0; a < 16; a += 2) rdc(4'(a));
        $display("test reset done");
        v = $urandom;
        gap <= 2'($urandom_range(3, 1));
        wr(4'h4, v);
        chkVal(32'(tempCoeffEn), {31'h0, v[0]});
        avs_byteenable <= 4'h0;
        wr(4'h4, ~v);
        avs_byteenable <= 4'hF;
        rdc(4'h4);
        $display("test registers done");
        wr(4'h0, 32'h1);
        waitMode(nextMode(mdl[0]), 8);
        pulse(1);
        repeat (5) @(posedge clk);
        waitMode(PMC_IDLE, 0);
        rdc(4'hC);
        rdc(4'h4);
        pulse(0);
        mdl[0][0] = 1'b0;
        waitMode(PMC_RUN, 0);
        rdc(4'h0);
        $display("test idle done");
        wr(4'h8, 32'h1);
        // kicks spaced well inside the timeout keep the core running
        repeat (8) wr(4'h8, 32'h5);
        waitMode(PMC_RUN, 0);
        wr(4'h0, 32'h1);
        waitMode(PMC_IDLE, 8);
        rstModel(2, WDT + 5);
        $display("test watchdog done");
        wr(4'h8, 32'h2);
        wr(4'h0, 32'h2);
        waitMode(PMC_STOP, 8);
        chkVal(32'({intOscEn, periphClkEn, irqEn}), 32'h0);
        pulse(0);
        waitMode(PMC_STOP, 0);
        // frozen clock enable must hold the detector count
        ce <= 1'b0;
        repeat (2 * MISSING_CLOCK_DETECTOR) @(posedge clk);
        ce <= 1'b1;
        waitMode(PMC_STOP, 0);
        rstModel(3, MISSING_CLOCK_DETECTOR + 10);
        $display("test detector done");
        wr(4'h8, 32'h0);
        wr(4'h0, 32'h7);
        waitMode(nextMode(mdl[0]), 8);
        repeat (2 * MISSING_CLOCK_DETECTOR) @(posedge clk);
        waitMode(PMC_STOP, 0);
        pulse(2);
        rstModel(1, 3);
        $display("test stop done");
        wr(4'h4, 32'h1);
        wr(4'h0, 32'h4);
        waitMode(nextMode(mdl[0]), 8);
        chkVal(32'(intOscEn), 32'h0);
        pulse(0);
        waitMode(PMC_SUSPEND, 0);
        pulse(1);
        mdl[0] = 32'h0;
        waitMode(PMC_RUN, 0);
        rdc(4'h0);
        $display("test suspend done");
        testDone;
    end

    // cuts a hang well beyond the expected run
    initial begin
        repeat (4000) @(posedge clk);
        nMismatch++;
        $display("ERROR t=%0t run did not finish in time", $time);
        testDone;
    end
endmodule : tb_cpu_power_mode_control
